/* hdl/irq_src_pkg.sv */
/*
 * Shared constants for the interrupt request sources block: register
 * offsets, field layouts, reset values, vector numbers and state codes.
 * Assumes a 32-bit classic Wishbone bus with byte addressing.
 */
package irq_src_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_PINS   = 8;
    localparam int NUM_GRP    = 4;
    localparam int ADDR_W     = 8;
    localparam int CNT_W      = 8;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_DELAY   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LEVEL   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ENABLE  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_FLAG    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_LVLCTL  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_XCOUNT  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_PINS    = 8'h20;

    // ==========================================================
    // Field positions and widths
    localparam int DELAY_BIT  = 0;
    localparam int ST_W       = 6;
    localparam int ST_GRP_LSB = 0;
    localparam int ST_DONE    = 4;
    localparam int ST_DELAY   = 5;

    // ==========================================================
    // Detection codes, two bits per pin
    localparam logic [1:0] DET_LOW  = 2'h0;
    localparam logic [1:0] DET_HIGH = 2'h1;
    localparam logic [1:0] DET_RISE = 2'h2;
    localparam logic [1:0] DET_FALL = 2'h3;

    // ==========================================================
    // Reset values
    localparam logic [15:0]      LEVEL_RST  = 16'h0000;
    localparam logic [7:0]       ENABLE_RST = 8'h00;
    localparam logic [7:0]       FLAG_RST   = 8'h00;
    localparam logic [3:0]       LVLCTL_RST = 4'h0;
    localparam logic [CNT_W-1:0] XCOUNT_RST = 8'h00;
    localparam logic [ST_W-1:0]  MASK_RST   = 6'h00;

    // ==========================================================
    // Vector numbers
    localparam logic [7:0] VEC_DELAY = 8'h2A;
    localparam logic [7:0] VEC_EXT0  = 8'h0F;
    localparam logic [7:0] VEC_EXT1  = 8'h14;
    localparam logic [7:0] VEC_EXT2  = 8'h18;
    localparam logic [7:0] VEC_EXT3  = 8'h1B;
    localparam logic [7:0] VEC_NONE  = 8'h00;

    // ==========================================================
    // Transfer service sequencer
    typedef enum logic [1:0] {
        XS_IDLE = 2'b01,
        XS_WAIT = 2'b10
    } xfer_state_e;

endpackage

/* hdl/ext_pin_detect.sv */
/*
 * Synchronises the external request pins and detects the selected
 * level or edge on each one.
 * Assumes asynchronous pins and a level-only flag per pin from the parent.
 */
module ext_pin_detect
    import irq_src_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic [irq_src_pkg::NUM_PINS-1:0]   pins_i,
    input  wire logic [2*irq_src_pkg::NUM_PINS-1:0] det_sel_i,
    input  wire logic [irq_src_pkg::NUM_PINS-1:0]   level_only_i,
    output logic      [irq_src_pkg::NUM_PINS-1:0]   state_o,
    output logic      [irq_src_pkg::NUM_PINS-1:0]   hit_o
);
    import irq_src_pkg::*;

    logic [NUM_PINS-1:0] meta_q, meta_d;
    logic [NUM_PINS-1:0] sync_q, sync_d;
    logic [NUM_PINS-1:0] prev_q, prev_d;
    logic [1:0]          code;

    // ==========================================================
    // Two-stage synchroniser plus one history sample
    always_comb begin
        meta_d = pins_i;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // ==========================================================
    // Detection; edges compare two synchronised samples
    always_comb begin
        code  = DET_LOW;
        hit_o = '0;
        for (int i = 0; i < NUM_PINS; i++) begin
            code = det_sel_i[2*i +: 2];
            // Transfer use knows levels only
            if (level_only_i[i]) begin
                code = {1'b0, code[0]};
            end
            case (code)
                DET_LOW:  hit_o[i] = ~sync_q[i];
                DET_HIGH: hit_o[i] = sync_q[i];
                DET_RISE: hit_o[i] = sync_q[i] & ~prev_q[i];
                DET_FALL: hit_o[i] = ~sync_q[i] & prev_q[i];
                default:  hit_o[i] = 1'b0;
            endcase
        end
    end

    assign state_o = sync_q;

endmodule // ext_pin_detect

/* hdl/irq_request_sources.sv */
/*
 * Interrupt request sources: a software delayed interrupt and eight
 * external request pins with per-pin detection, enable and flag, grouped
 * onto four vectors, optionally first served by an automatic transfer.
 * Assumes a classic Wishbone master on the same clock, a CPU interrupt
 * controller reading the request lines, and a transfer engine that answers
 * each transfer request with a one-cycle done pulse.
 */
// Added by the designer: the register addresses and the Wishbone register port.
// Notes on behaviour
// - Writing one to the delayed request bit raises the delayed request.
// - Writing zero to the delayed request bit withdraws the delayed request.
// - The delayed request is presented on its fixed vector number.
// - No enable for the delayed request; output follows the bit directly.
// - The delayed request bit reads back as the pending flag.
// - The delayed request never starts the automatic transfer service.
// - Each of eight pins has its own detection code in the select register.
// - Interrupt use: high, low, rise, fall; transfer use: levels only.
// - A per-pin enable gates whether a detected condition makes a request.
// - A detected condition sets the pin's flag bit.
// - Service select zero: an enabled request goes straight to the interrupt.
// - Service select one: each request runs one transfer until count exhausted.
// - Eight pins reach the controller on four vectors, two pins each.
module irq_request_sources
    import irq_src_pkg::*;
(
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_i,
    // Wishbone slave
    input  wire logic                                 cyc_i,
    input  wire logic                                 stb_i,
    input  wire logic                                 we_i,
    input  wire logic [irq_src_pkg::ADDR_W-1:0]       adr_i,
    input  wire logic [3:0]                           sel_i,
    input  wire logic [31:0]                          dat_i,
    output logic      [31:0]                          dat_o,
    output logic                                      ack_o,
    // External request pins
    input  wire logic [irq_src_pkg::NUM_PINS-1:0]     ext_pins_i,
    // Toward the CPU interrupt controller
    output logic                                      delayed_req_o,
    output logic [irq_src_pkg::NUM_GRP-1:0]           ext_req_o,
    output logic                                      cpu_req_o,
    output logic [7:0]                                cpu_vec_o,
    // Automatic transfer service
    output logic                                      xfer_req_o,
    output logic [1:0]                                xfer_grp_o,
    input  wire logic                                 xfer_done_i,
    // Block interrupt
    output logic                                      irq_o
);
    import irq_src_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [7:0] grp_vec(input logic [1:0] g);
        case (g)
            2'd0:    grp_vec = VEC_EXT0;
            2'd1:    grp_vec = VEC_EXT1;
            2'd2:    grp_vec = VEC_EXT2;
            default: grp_vec = VEC_EXT3;
        endcase
    endfunction

    function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [7:0] nw,
                                              input logic en);
        lane_merge = en ? nw : old;
    endfunction

    // ==========================================================
    // Declarations
    logic                  delay_q, delay_d;
    logic [15:0]           level_q, level_d;
    logic [NUM_PINS-1:0]   enable_q, enable_d;
    logic [NUM_PINS-1:0]   flag_q, flag_d;
    logic [NUM_GRP-1:0]    lvlctl_q, lvlctl_d;
    logic [4*CNT_W-1:0]    xcount_q, xcount_d;
    logic [ST_W-1:0]       status_q, status_d;
    logic [ST_W-1:0]       mask_q, mask_d;
    logic                  ack_q, ack_d;
    logic [31:0]           rdata_q, rdata_d;
    xfer_state_e           xs_q, xs_d;
    logic [1:0]            xgrp_q, xgrp_d;
    logic                  xreq_q, xreq_d;
    logic [NUM_GRP-1:0]    ext_req_q, ext_req_d;
    logic                  cpu_req_q, cpu_req_d;
    logic [7:0]            cpu_vec_q, cpu_vec_d;

    logic [NUM_PINS-1:0]   pin_state;
    logic [NUM_PINS-1:0]   pin_hit;
    logic [NUM_PINS-1:0]   level_only;
    logic [NUM_GRP-1:0]    grp_pend;
    logic [NUM_GRP-1:0]    grp_cnt_zero;
    logic [NUM_GRP-1:0]    grp_xfer;
    logic                  bus_wr;
    logic                  bus_rd;

    // ==========================================================
    // Pin detection
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            level_only[i] = lvlctl_q[i/2];
        end
    end

    ext_pin_detect u_detect (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .pins_i       (ext_pins_i),
        .det_sel_i    (level_q),
        .level_only_i (level_only),
        .state_o      (pin_state),
        .hit_o        (pin_hit)
    );

    // ==========================================================
    // Bus access; writes and read side effects happen on the ack edge
    assign bus_wr = cyc_i & stb_i & ack_q & we_i;
    assign bus_rd = cyc_i & stb_i & ack_q & ~we_i;

    always_comb begin
        ack_d   = cyc_i & stb_i & ~ack_q;
        rdata_d = rdata_q;
        if (cyc_i && stb_i && !ack_q) begin
            rdata_d = '0;
            case (adr_i)
                OFS_DELAY:  rdata_d[DELAY_BIT] = delay_q;
                OFS_LEVEL:  rdata_d[15:0] = level_q;
                OFS_ENABLE: rdata_d[NUM_PINS-1:0] = enable_q;
                OFS_FLAG:   rdata_d[NUM_PINS-1:0] = flag_q;
                OFS_LVLCTL: rdata_d[NUM_GRP-1:0] = lvlctl_q;
                OFS_XCOUNT: rdata_d = xcount_q;
                OFS_STATUS: rdata_d[ST_W-1:0] = status_q;
                OFS_MASK:   rdata_d[ST_W-1:0] = mask_q;
                OFS_PINS:   rdata_d[NUM_PINS-1:0] = pin_state;
                default:    rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdata_q;

    // ==========================================================
    // Configuration registers and delayed request
    always_comb begin
        delay_d  = delay_q;
        level_d  = level_q;
        enable_d = enable_q;
        lvlctl_d = lvlctl_q;
        mask_d   = mask_q;
        if (bus_wr) begin
            case (adr_i)
                OFS_DELAY: begin
                    // One raises, zero withdraws; nothing else gates it
                    if (sel_i[0]) delay_d = dat_i[DELAY_BIT];
                end
                OFS_LEVEL: begin
                    level_d[7:0]  = lane_merge(level_q[7:0], dat_i[7:0], sel_i[0]);
                    level_d[15:8] = lane_merge(level_q[15:8], dat_i[15:8], sel_i[1]);
                end
                OFS_ENABLE: enable_d = lane_merge(enable_q, dat_i[7:0], sel_i[0]);
                OFS_LVLCTL: begin
                    if (sel_i[0]) lvlctl_d = dat_i[NUM_GRP-1:0];
                end
                OFS_MASK: begin
                    if (sel_i[0]) mask_d = dat_i[ST_W-1:0];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            delay_q  <= 1'b0;
            level_q  <= LEVEL_RST;
            enable_q <= ENABLE_RST;
            lvlctl_q <= LVLCTL_RST;
            mask_q   <= MASK_RST;
        end else begin
            delay_q  <= delay_d;
            level_q  <= level_d;
            enable_q <= enable_d;
            lvlctl_q <= lvlctl_d;
            mask_q   <= mask_d;
        end
    end

    // ==========================================================
    // Flags and group requests
    always_comb begin
        for (int g = 0; g < NUM_GRP; g++) begin
            grp_pend[g]     = |(flag_q[2*g +: 2] & enable_q[2*g +: 2]);
            grp_cnt_zero[g] = (xcount_q[g*CNT_W +: CNT_W] == '0);
            grp_xfer[g]     = grp_pend[g] & lvlctl_q[g] & ~grp_cnt_zero[g];
        end
    end

    always_comb begin
        flag_d = flag_q;
        // Writing zero clears; writing one leaves the flag alone
        if (bus_wr && adr_i == OFS_FLAG && sel_i[0]) begin
            flag_d = flag_q & dat_i[NUM_PINS-1:0];
        end
        // The transfer engine consumes the pair that asked for it
        if (xs_q == XS_WAIT && xfer_done_i) begin
            flag_d[2*xgrp_q +: 2] = 2'b00;
        end
        // Detection wins over any clear in the same cycle
        flag_d = flag_d | pin_hit;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= FLAG_RST;
        end else begin
            flag_q <= flag_d;
        end
    end

    // ==========================================================
    // Transfer service sequencer; one transfer in flight at a time
    always_comb begin
        xs_d     = xs_q;
        xgrp_d   = xgrp_q;
        xreq_d   = 1'b0;
        xcount_d = xcount_q;
        if (bus_wr && adr_i == OFS_XCOUNT) begin
            for (int b = 0; b < 4; b++) begin
                xcount_d[8*b +: 8] = lane_merge(xcount_q[8*b +: 8], dat_i[8*b +: 8], sel_i[b]);
            end
        end
        case (xs_q)
            XS_IDLE: begin
                // Lowest group first; the delayed request never enters here
                for (int g = NUM_GRP - 1; g >= 0; g--) begin
                    if (grp_xfer[g]) begin
                        xgrp_d = g[1:0];
                        xreq_d = 1'b1;
                        xs_d   = XS_WAIT;
                    end
                end
            end
            XS_WAIT: begin
                if (xfer_done_i) begin
                    xcount_d[xgrp_q*CNT_W +: CNT_W] =
                        xcount_q[xgrp_q*CNT_W +: CNT_W] - 8'h01;
                    xs_d = XS_IDLE;
                end
            end
            default: xs_d = XS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xs_q     <= XS_IDLE;
            xgrp_q   <= 2'd0;
            xreq_q   <= 1'b0;
            xcount_q <= {4{XCOUNT_RST}};
        end else begin
            xs_q     <= xs_d;
            xgrp_q   <= xgrp_d;
            xreq_q   <= xreq_d;
            xcount_q <= xcount_d;
        end
    end

    assign xfer_req_o = xreq_q;
    assign xfer_grp_o = xgrp_q;

    // ==========================================================
    // Requests toward the CPU; lowest vector number wins the shared line
    always_comb begin
        for (int g = 0; g < NUM_GRP; g++) begin
            // Direct when select is zero, or after the count runs out
            ext_req_d[g] = grp_pend[g] & (~lvlctl_q[g] | grp_cnt_zero[g]);
        end
        cpu_req_d = delay_q | (|ext_req_d);
        cpu_vec_d = VEC_NONE;
        if (delay_q) begin
            cpu_vec_d = VEC_DELAY;
        end
        for (int g = NUM_GRP - 1; g >= 0; g--) begin
            if (ext_req_d[g]) cpu_vec_d = grp_vec(g[1:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_req_q <= '0;
            cpu_req_q <= 1'b0;
            cpu_vec_q <= VEC_NONE;
        end else begin
            ext_req_q <= ext_req_d;
            cpu_req_q <= cpu_req_d;
            cpu_vec_q <= cpu_vec_d;
        end
    end

    assign delayed_req_o = delay_q;
    assign ext_req_o     = ext_req_q;
    assign cpu_req_o     = cpu_req_q;
    assign cpu_vec_o     = cpu_vec_q;

    // ==========================================================
    // Block interrupt: sticky events, cleared by reading them
    always_comb begin
        status_d = status_q;
        if (bus_rd && adr_i == OFS_STATUS) begin
            // Clear only what the read returned; an event latched meanwhile survives
            status_d = status_q & ~rdata_q[ST_W-1:0];
        end
        // Event set beats the read clear in the same cycle
        for (int g = 0; g < NUM_GRP; g++) begin
            if (ext_req_d[g] && !ext_req_q[g]) status_d[ST_GRP_LSB + g] = 1'b1;
        end
        if (xs_q == XS_WAIT && xfer_done_i && xcount_q[xgrp_q*CNT_W +: CNT_W] == 8'h01) begin
            status_d[ST_DONE] = 1'b1;
        end
        if (delay_d && !delay_q) status_d[ST_DELAY] = 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    assign irq_o = |(status_q & mask_q);

endmodule // irq_request_sources

/* testbench/irq_request_sources_properties.sv */
/*
 * Concurrent checks on the ports of irq_request_sources.
 * Assumes one clock and a synchronous active-high reset; bound below.
 */
module irq_request_sources_checker
    import irq_src_pkg::*;
(
    input wire logic                             clk_i,
    input wire logic                             rst_i,
    input wire logic                             cyc_i,
    input wire logic                             stb_i,
    input wire logic                             we_i,
    input wire logic [irq_src_pkg::ADDR_W-1:0]   adr_i,
    input wire logic [3:0]                       sel_i,
    input wire logic [31:0]                      dat_i,
    input wire logic                             ack_o,
    input wire logic                             delayed_req_o,
    input wire logic [irq_src_pkg::NUM_GRP-1:0]  ext_req_o,
    input wire logic                             cpu_req_o,
    input wire logic [7:0]                       cpu_vec_o,
    input wire logic                             xfer_req_o,
    input wire logic [1:0]                       xfer_grp_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ==========
    // Sequences
    sequence take_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence dly_wr_s;
        take_s ##0 (we_i && sel_i[0] && adr_i == OFS_DELAY);
    endsequence

    // ==========
    // Properties
    bus_ack_a: assert property (take_s |=> ack_o ##1 !ack_o)
        else $error("bus answer is not one pulse");
    delay_set_a: assert property (dly_wr_s ##0 dat_i[0] |-> ##2 delayed_req_o)
        else $error("delayed request not raised");
    delay_clr_a: assert property (dly_wr_s ##0 !dat_i[0] |-> ##2 !delayed_req_o)
        else $error("delayed request not withdrawn");
    delay_vec_a: assert property ($past(delayed_req_o) && ext_req_o == '0 |->
        cpu_req_o && cpu_vec_o == VEC_DELAY)
        else $error("delayed vector wrong");
    req_any_a: assert property (cpu_req_o == ($past(delayed_req_o) || (|ext_req_o)))
        else $error("cpu request not following sources");
    vec_first_a: assert property (ext_req_o[0] |-> cpu_vec_o == VEC_EXT0)
        else $error("first group vector wrong");
    xfer_pulse_a: assert property (xfer_req_o |=> !xfer_req_o)
        else $error("transfer start longer than a pulse");
    xfer_excl_a: assert property (xfer_req_o |-> !ext_req_o[xfer_grp_o])
        else $error("transfer and interrupt together");
endmodule // irq_request_sources_checker

bind irq_request_sources irq_request_sources_checker chk_u (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o,
    .delayed_req_o, .ext_req_o, .cpu_req_o, .cpu_vec_o, .xfer_req_o, .xfer_grp_o
);

/* testbench/xfer_engine_model.sv */
/*
 * Behavioural transfer engine answering each start pulse with one done pulse.
 * Assumes the same clock as the block; delay_i sets the answer latency.
 */
module xfer_engine_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic [3:0]  delay_i,
    output logic             done_o,
    output int               starts_o
);
    logic        busy_q;
    logic [3:0]  cnt_q;

    // ==========
    // One transfer at a time; a start while busy restarts the count
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            busy_q   <= 1'b0;
            cnt_q    <= 4'h0;
            starts_o <= 0;
        end else if (req_i) begin
            busy_q   <= 1'b1;
            cnt_q    <= delay_i;
            starts_o <= starts_o + 1;
        end else if (busy_q) begin
            if (cnt_q == 4'h0) begin
                done_o <= 1'b1;
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule // xfer_engine_model

/* testbench/irq_request_sources_bench.sv */
/*
 * Self-checking bench for irq_request_sources.
 * Assumes a Wishbone master here and the transfer engine model.
 */
module irq_request_sources_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_src_pkg::*;

    logic        clk_i, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00, ext_pins_i = 8'h00, cpu_vec_o;
    logic [3:0]  sel_i = 4'h0, ext_req_o, delay = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, rd;
    logic        ack_o, delayed_req_o, cpu_req_o, xfer_req_o, xfer_done_i, irq_o;
    logic [1:0]  xfer_grp_o;
    int          starts, errors = 0, tests_run = 0;

    irq_request_sources DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .ext_pins_i, .delayed_req_o, .ext_req_o, .cpu_req_o, .cpu_vec_o,
        .xfer_req_o, .xfer_grp_o, .xfer_done_i, .irq_o);
    xfer_engine_model ENG (.clk_i, .rst_i, .req_i(xfer_req_o), .delay_i(delay),
        .done_o(xfer_done_i), .starts_o(starts));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ==========
    // Shared tasks
    task finish_test;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h", $time, m, got);
        end
    endtask

    // Holds the request until ack is sampled, then leaves a gap cycle
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            finish_test();
        end
        rd = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // ==========
    // Scenarios
    task t_regs;
        for (int a = 0; a <= 'h24; a += 4) begin
            wb(0, a[7:0], 0);
            // Low-level detect is the reset code and pins idle low, so all flags set
            chk(rd, (a == OFS_FLAG) ? 32'h0000_00ff : 32'h0000_0000, "reset value");
        end
        wb(1, 8'h24, 32'hffff_ffff);
        wb(0, 8'h24, 0);
        chk(rd, 0, "unmapped");
        wb(1, OFS_ENABLE, 32'h0000_00a5);
        wb(0, OFS_ENABLE, 0);
        chk(rd, 32'h0000_00a5, "enable readback");
        wb(1, OFS_ENABLE, 0);
    endtask

    task t_detect;
        logic [1:0] code [4];
        logic       b;
        code = '{DET_LOW, DET_HIGH, DET_RISE, DET_FALL};
        for (int i = 0; i < 4; i++) begin
            b = (i == 0 || i == 3);
            ext_pins_i <= {7'h00, b};
            wb(1, OFS_LEVEL, {16'h0000, 14'h1555, code[i]});
            repeat (5) @(posedge clk_i);
            wb(1, OFS_FLAG, 0);
            wb(0, OFS_FLAG, 0);
            chk(rd, 0, "flag while idle");
            ext_pins_i <= {7'h00, ~b};
            repeat (5) @(posedge clk_i);
            wb(0, OFS_FLAG, 0);
            chk(rd, 1, "flag on condition");
            chk(ext_req_o, 0, "request while disabled");
            wb(1, OFS_ENABLE, 1);
            repeat (2) @(posedge clk_i);
            chk(ext_req_o, 4'h1, "request when enabled");
            chk(cpu_vec_o, VEC_EXT0, "vector when enabled");
            ext_pins_i <= {7'h00, b};
            repeat (5) @(posedge clk_i);
            wb(1, OFS_ENABLE, 0);
            wb(1, OFS_FLAG, 0);
        end
    endtask

    task t_groups;
        logic [7:0] vec [4];
        vec = '{VEC_EXT0, VEC_EXT1, VEC_EXT2, VEC_EXT3};
        wb(1, OFS_LEVEL, 32'h0000_5555);
        for (int p = 0; p < 8; p++) begin
            ext_pins_i <= 8'h01 << p;
            wb(1, OFS_ENABLE, 32'h1 << p);
            repeat (5) @(posedge clk_i);
            chk(ext_req_o, 4'h1 << (p / 2), "group of pin");
            chk(cpu_vec_o, vec[p / 2], "group vector");
            ext_pins_i <= 8'h00;
            repeat (4) @(posedge clk_i);
            wb(1, OFS_ENABLE, 0);
            wb(1, OFS_FLAG, 0);
        end
    endtask

    task t_delayed;
        int s0;
        wb(1, OFS_LVLCTL, 32'h0000_000f);
        wb(0, OFS_STATUS, 0);
        wb(1, OFS_MASK, 0);
        s0 = starts;
        wb(1, OFS_DELAY, 1);
        chk(delayed_req_o, 1, "delayed raised");
        @(posedge clk_i);
        chk(cpu_vec_o, VEC_DELAY, "delayed vector");
        chk(irq_o, 0, "masked interrupt");
        wb(0, OFS_DELAY, 0);
        chk(rd, 1, "pending readback");
        wb(1, OFS_MASK, 32'h0000_0020);
        chk(irq_o, 1, "unmasked interrupt");
        wb(0, OFS_STATUS, 0);
        chk(rd, 32'h0000_0020, "status event");
        chk(irq_o, 0, "status cleared by read");
        chk(starts, s0, "no transfer for delayed");
        wb(1, OFS_DELAY, 0);
        chk(delayed_req_o, 0, "delayed withdrawn");
        wb(0, OFS_DELAY, 0);
        chk(rd, 0, "withdrawn readback");
        wb(1, OFS_LVLCTL, 0);
        wb(1, OFS_MASK, 0);
    endtask

    // Falling code in transfer use must act as high level, so a held pin retriggers
    task t_xfer;
        int s0, n;
        wb(1, OFS_LEVEL, 32'h0000_00c0);
        wb(1, OFS_LVLCTL, 32'h0000_0002);
        wb(1, OFS_XCOUNT, 32'h0000_0200);
        wb(0, OFS_STATUS, 0);
        s0 = starts;
        delay <= 4'h5;
        ext_pins_i <= 8'h08;
        wb(1, OFS_ENABLE, 32'h0000_0008);
        n = 0;
        while (!(ext_req_o === 4'h2 && starts == s0 + 2) && n < 300) begin
            @(posedge clk_i);
            if (xfer_req_o === 1'b1) chk(xfer_grp_o, 2'h1, "transfer group");
            if (starts > s0) delay <= 4'h0;
            n++;
        end
        if (n >= 300) begin
            errors++;
            finish_test();
        end
        chk(starts - s0, 2, "transfer count");
        chk(ext_req_o, 4'h2, "interrupt after transfers");
        wb(0, OFS_STATUS, 0);
        chk(rd, 32'h0000_0012, "count reached status");
        ext_pins_i <= 8'h00;
        repeat (5) @(posedge clk_i);
        wb(1, OFS_ENABLE, 0);
        wb(1, OFS_FLAG, 0);
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_detect();
        t_groups();
        t_delayed();
        t_xfer();
        finish_test();
    end
endmodule // irq_request_sources_bench
